// >>> ldo_ctrl_map.svh
// Purpose: constants for the regulator enable and mode control block
// Assumes: one 250 MHz clock
// Notes: regulator index order is pll, gen1, usb, dac, usb2, gen2
`ifndef LDO_CTRL_MAP_SVH
`define LDO_CTRL_MAP_SVH
`define LDO_COUNT        6
`define IDX_PLL          0
`define IDX_GEN1         1
`define IDX_USB          2
`define IDX_DAC          3
`define IDX_USB2         4
`define IDX_GEN2         5
`define MODE_CAPABLE     6'h38
`define SCP_COVERED      6'h3E
`define SCP_DEBOUNCE     4'h8
`define SLEEP_DLY_W      8
`define PLL_SEL_RESET    2'h0
`endif

// >>> ldo_ctrl_pkg.sv
// Purpose: types for the regulator control block
// Assumes: nothing
// Notes: output state of one regulator
package ldo_ctrl_pkg;
  typedef enum logic [1:0] {REG_OFF, REG_ON, REG_LOW_POWER} reg_state_t;
endpackage : ldo_ctrl_pkg

// >>> fault_debounce.sv
// Purpose: per-regulator synchroniser and debounce for fault inputs
// Assumes: raw level from an analog comparator
// Notes: reports a one-cycle pulse once the level has been stable
`timescale 1ns/10ps
`include "ldo_ctrl_map.svh"
module fault_debounce #(
  parameter int CNT = 8
) (
  input  wire logic sys_clk_i,
  input  wire logic rst_i,
  input  wire logic raw_i,
  output logic      fault_o
);
  logic [2:0] sync_r;
  logic [3:0] cnt_r;
  logic [3:0] cnt_nxt;
  logic       hit_r;
  logic       hit_nxt;
  logic       stable;

  assign stable  = sync_r[1] & sync_r[2];
  assign fault_o = hit_r;

  always_comb begin
    cnt_nxt = cnt_r;
    hit_nxt = 1'b0;
    if (!stable) begin
      cnt_nxt = 4'h0;
    end else if (cnt_r < 4'(CNT)) begin
      cnt_nxt = cnt_r + 4'h1;
      hit_nxt = (cnt_r == 4'(CNT - 1));
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      sync_r <= 3'h0;
      cnt_r  <= 4'h0;
      hit_r  <= 1'b0;
    end else begin
      sync_r <= {sync_r[1:0], raw_i};
      cnt_r  <= cnt_nxt;
      hit_r  <= hit_nxt;
    end
  end
endmodule : fault_debounce

// >>> ldo_enable_mode_control.sv
// Purpose: enable, low-power and standby control of six linear regulators
// Assumes: host writes control bits through a load strobe
// Notes: short-circuit protection clears enable bits and flags an interrupt
`timescale 1ns/10ps
`include "ldo_ctrl_map.svh"
// How it works
// - external pass: off when disabled, mode picks on or low power
// - participation bit clear means standby request has no effect
// - internal pass: off disabled, on enabled, off in participating standby
// - readback shows programmed bits, not the live operating state
// - pll, general 1 and usb regulators have no mode bit
// - dac regulator mode follows only its host-written mode bit
// - usb 2 and general 2 low power follows their mode bit
// - standby can disable chosen regulators and force chosen outputs low
// - standby reaches regulators after a programmable delay
// - debounced short protection on dac, usb, usb 2, general 1, 2
// - protected short clears that enable bit and sets the interrupt flag
// - mask bit keeps the flag from reaching the processor
// - protection disabled: short neither flags nor clears enable
// - protection enable resets cleared
// - pll supply takes a two-bit voltage select
// - disabled regulator or low reset pin turns on output pull-down
module ldo_enable_mode_control
  import ldo_ctrl_pkg::*;
#(
  parameter int N    = `LDO_COUNT,
  parameter int NGPO = 4
) (
  input  wire logic                    sys_clk_i,
  input  wire logic                    rst_i,
  input  wire logic                    reset_n_input_i,
  input  wire logic                    standby_req_i,
  input  wire logic [N-1:0]            short_detect_i,
  input  wire logic                    cfg_load_i,
  input  wire logic [N-1:0]            regulator_enable_bit_i,
  input  wire logic [N-1:0]            low_power_select_bit_i,
  input  wire logic [N-1:0]            standby_participation_bit_i,
  input  wire logic [NGPO-1:0]         gpo_standby_low_i,
  input  wire logic [NGPO-1:0]         gpo_value_i,
  input  wire logic [`SLEEP_DLY_W-1:0] sleep_response_delay_i,
  input  wire logic                    short_protect_enable_i,
  input  wire logic                    short_circuit_irq_mask_i,
  input  wire logic                    short_irq_clear_i,
  input  wire logic [1:0]              pll_supply_voltage_select_i,
  output logic [N-1:0]                 regulator_enable_bit_o,
  output logic [N-1:0]                 low_power_select_bit_o,
  output logic [N-1:0]                 standby_participation_bit_o,
  output logic                         short_protect_enable_o,
  output logic                         short_circuit_irq_o,
  output logic                         short_irq_n_o,
  output logic [1:0]                   pll_supply_voltage_select_o,
  output reg_state_t                   reg_state_o [N],
  output logic [N-1:0]                 pull_down_o,
  output logic [NGPO-1:0]              gpo_o
);
  localparam logic [N-1:0] MODE_CAP = `MODE_CAPABLE;
  localparam logic [N-1:0] SCP_COV  = `SCP_COVERED;

  logic [N-1:0]            en_r, en_nxt, mode_r, mode_nxt, stby_r, stby_nxt;
  logic                    scpen_r, scpen_nxt, irq_r, irq_nxt;
  logic                    mask_r, mask_nxt;
  logic [1:0]              pll_r, pll_nxt;
  logic [NGPO-1:0]         gsl_r, gsl_nxt, gval_r, gval_nxt, gpo_r, gpo_nxt;
  logic [`SLEEP_DLY_W-1:0] dly_r, dly_nxt, cnt_r, cnt_nxt;
  logic                    stb_eff_r, stb_eff_nxt;
  logic [2:0]              stb_sync_r, rstn_sync_r;
  logic                    stb_s, rstn_s;
  logic                    stb_hold_r, rstn_hold_r;
  logic [N-1:0]            fault, trip;
  reg_state_t              st_r [N];
  reg_state_t              st_nxt [N];
  logic [N-1:0]            pd_r, pd_nxt;

  // three-stage sync, a change counts once stages two and three agree
  always_comb begin
    stb_s  = stb_hold_r;
    rstn_s = rstn_hold_r;
    if (stb_sync_r[1] == stb_sync_r[2]) begin
      stb_s = stb_sync_r[2];
    end
    if (rstn_sync_r[1] == rstn_sync_r[2]) begin
      rstn_s = rstn_sync_r[2];
    end
  end

  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_scp
      if (SCP_COV[g]) begin : g_cov
        fault_debounce #(.CNT(`SCP_DEBOUNCE)) u_deb (
          .sys_clk_i (sys_clk_i),
          .rst_i     (rst_i),
          .raw_i     (short_detect_i[g]),
          .fault_o   (fault[g])
        );
      end else begin : g_none
        assign fault[g] = 1'b0;
      end
    end
  endgenerate

  assign trip = scpen_r ? (fault & en_r) : '0;

  // control bits
  always_comb begin
    en_nxt    = en_r;
    mode_nxt  = mode_r;
    stby_nxt  = stby_r;
    scpen_nxt = scpen_r;
    mask_nxt  = mask_r;
    pll_nxt   = pll_r;
    gsl_nxt   = gsl_r;
    gval_nxt  = gval_r;
    dly_nxt   = dly_r;
    irq_nxt   = irq_r;
    if (cfg_load_i) begin
      en_nxt    = regulator_enable_bit_i;
      mode_nxt  = low_power_select_bit_i & MODE_CAP;
      stby_nxt  = standby_participation_bit_i;
      scpen_nxt = short_protect_enable_i;
      mask_nxt  = short_circuit_irq_mask_i;
      pll_nxt   = pll_supply_voltage_select_i;
      gsl_nxt   = gpo_standby_low_i;
      gval_nxt  = gpo_value_i;
      dly_nxt   = sleep_response_delay_i;
    end
    en_nxt = en_nxt & ~trip;
    if (short_irq_clear_i) begin
      irq_nxt = 1'b0;
    end
    if (|trip) begin
      irq_nxt = 1'b1;
    end
  end

  // delayed standby
  always_comb begin
    cnt_nxt     = cnt_r;
    stb_eff_nxt = stb_eff_r;
    if (stb_s == stb_eff_r) begin
      cnt_nxt = '0;
    end else if (cnt_r >= dly_r) begin
      stb_eff_nxt = stb_s;
      cnt_nxt     = '0;
    end else begin
      cnt_nxt = cnt_r + 1'b1;
    end
    gpo_nxt = stb_eff_r ? (gval_r & ~gsl_r) : gval_r;
  end

  // per-regulator state
  always_comb begin
    for (int i = 0; i < N; i++) begin
      if (!en_r[i]) begin
        st_nxt[i] = REG_OFF;
      end else if (!stby_r[i] || !stb_eff_r) begin
        st_nxt[i] = (MODE_CAP[i] && mode_r[i]) ? REG_LOW_POWER : REG_ON;
      end else if (MODE_CAP[i] && mode_r[i]) begin
        st_nxt[i] = REG_LOW_POWER;
      end else begin
        st_nxt[i] = REG_OFF;
      end
      pd_nxt[i] = (st_nxt[i] == REG_OFF) || !rstn_s;
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      en_r        <= '0;
      mode_r      <= '0;
      stby_r      <= '0;
      scpen_r     <= 1'b0;
      mask_r      <= 1'b0;
      irq_r       <= 1'b0;
      pll_r       <= `PLL_SEL_RESET;
      gsl_r       <= '0;
      gval_r      <= '0;
      gpo_r       <= '0;
      dly_r       <= '0;
      cnt_r       <= '0;
      stb_eff_r   <= 1'b0;
      stb_sync_r  <= 3'h0;
      rstn_sync_r <= 3'h7;
      stb_hold_r  <= 1'b0;
      rstn_hold_r <= 1'b1;
      pd_r        <= '1;
      for (int i = 0; i < N; i++) begin
        st_r[i] <= REG_OFF;
      end
    end else begin
      en_r        <= en_nxt;
      mode_r      <= mode_nxt;
      stby_r      <= stby_nxt;
      scpen_r     <= scpen_nxt;
      mask_r      <= mask_nxt;
      irq_r       <= irq_nxt;
      pll_r       <= pll_nxt;
      gsl_r       <= gsl_nxt;
      gval_r      <= gval_nxt;
      gpo_r       <= gpo_nxt;
      dly_r       <= dly_nxt;
      cnt_r       <= cnt_nxt;
      stb_eff_r   <= stb_eff_nxt;
      stb_sync_r  <= {stb_sync_r[1:0], standby_req_i};
      rstn_sync_r <= {rstn_sync_r[1:0], reset_n_input_i};
      stb_hold_r  <= stb_s;
      rstn_hold_r <= rstn_s;
      pd_r        <= pd_nxt;
      st_r        <= st_nxt;
    end
  end

  assign regulator_enable_bit_o      = en_r;
  assign low_power_select_bit_o      = mode_r;
  assign standby_participation_bit_o = stby_r;
  assign short_protect_enable_o      = scpen_r;
  assign short_circuit_irq_o         = irq_r;
  assign short_irq_n_o               = ~(irq_r & ~mask_r);
  assign pll_supply_voltage_select_o = pll_r;
  assign reg_state_o                 = st_r;
  assign pull_down_o                 = pd_r;
  assign gpo_o                       = gpo_r;

  property p_trip_clears;
    @(posedge sys_clk_i) disable iff (rst_i)
      (|trip) |=> (short_circuit_irq_o && ((en_r & $past(trip)) == '0));
  endproperty
  a_trip_clears: assert property (p_trip_clears)
    else $error("short trip did not clear enable or set flag");

  property p_no_prot;
    @(posedge sys_clk_i) disable iff (rst_i)
      (!scpen_r && !cfg_load_i && !short_circuit_irq_o) |=>
        (!short_circuit_irq_o && en_r == $past(en_r));
  endproperty
  a_no_prot: assert property (p_no_prot)
    else $error("unprotected short changed state");

  property p_mask;
    @(posedge sys_clk_i) disable iff (rst_i)
      mask_r |-> short_irq_n_o;
  endproperty
  a_mask: assert property (p_mask)
    else $error("masked flag reached processor");

  property p_flag_holds;
    @(posedge sys_clk_i) disable iff (rst_i)
      (short_circuit_irq_o && !short_irq_clear_i) |=> short_circuit_irq_o;
  endproperty
  a_flag_holds: assert property (p_flag_holds)
    else $error("flag dropped without clear");

  property p_disabled_off;
    @(posedge sys_clk_i) disable iff (rst_i)
      !en_r[`IDX_DAC] |=> (reg_state_o[`IDX_DAC] == REG_OFF && pull_down_o[`IDX_DAC]);
  endproperty
  a_disabled_off: assert property (p_disabled_off)
    else $error("disabled regulator not off");

  property p_no_stby;
    @(posedge sys_clk_i) disable iff (rst_i)
      (en_r[`IDX_USB] && !stby_r[`IDX_USB]) |=> reg_state_o[`IDX_USB] == REG_ON;
  endproperty
  a_no_stby: assert property (p_no_stby)
    else $error("non participating regulator not on");

  property p_stby_lp;
    @(posedge sys_clk_i) disable iff (rst_i)
      (en_r[`IDX_GEN2] && stby_r[`IDX_GEN2] && stb_eff_r && mode_r[`IDX_GEN2])
        |=> reg_state_o[`IDX_GEN2] == REG_LOW_POWER;
  endproperty
  a_stby_lp: assert property (p_stby_lp)
    else $error("standby low power wrong");

  property p_int_stby_off;
    @(posedge sys_clk_i) disable iff (rst_i)
      (en_r[`IDX_GEN1] && stby_r[`IDX_GEN1] && stb_eff_r)
        |=> reg_state_o[`IDX_GEN1] == REG_OFF;
  endproperty
  a_int_stby_off: assert property (p_int_stby_off)
    else $error("internal pass not off in standby");

  property p_no_mode_bits;
    @(posedge sys_clk_i) disable iff (rst_i)
      mode_r[`IDX_PLL] == 1'b0 && mode_r[`IDX_USB] == 1'b0;
  endproperty
  a_no_mode_bits: assert property (p_no_mode_bits)
    else $error("mode bit stored for adaptive regulator");

  property p_delay;
    @(posedge sys_clk_i) disable iff (rst_i)
      (dly_r == 8'h00 && stb_s != stb_eff_r && !cfg_load_i) |=> stb_eff_r == $past(stb_s);
  endproperty
  a_delay: assert property (p_delay)
    else $error("zero delay standby not applied");

  property p_pin_pd;
    @(posedge sys_clk_i) disable iff (rst_i)
      !rstn_s |=> pull_down_o == '1;
  endproperty
  a_pin_pd: assert property (p_pin_pd)
    else $error("pin reset did not force pull-downs");

  property p_gpo_low;
    @(posedge sys_clk_i) disable iff (rst_i)
      stb_eff_r |=> (gpo_o & $past(gsl_r)) == '0;
  endproperty
  a_gpo_low: assert property (p_gpo_low)
    else $error("standby did not force chosen outputs low");

  c_trip:    cover property (@(posedge sys_clk_i) disable iff (rst_i) |trip);
  c_standby: cover property (@(posedge sys_clk_i) disable iff (rst_i) $rose(stb_eff_r));
  c_lp:      cover property (@(posedge sys_clk_i) disable iff (rst_i)
                             reg_state_o[`IDX_DAC] == REG_LOW_POWER);
  c_pin_pd:  cover property (@(posedge sys_clk_i) disable iff (rst_i) !rstn_s);
endmodule : ldo_enable_mode_control

// >>> ldo_irq_host.sv
// Purpose: processor side that services the short-circuit interrupt
// Assumes: interrupt line is low while a masked-in flag is pending
// Notes: one-cycle clear pulse, then waits for the line to go high
`timescale 1ns/10ps
module ldo_irq_host (
  input  wire logic sys_clk_i,
  input  wire logic rst_i,
  input  wire logic short_irq_n_i,
  input  wire logic service_en_i,
  output logic      irq_clear_o,
  output int        serviced_o
);
  logic busy_r;
  // changes just after the falling edge, seen by the design at the rising edge
  always @(negedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      irq_clear_o <= 1'b0;
      busy_r      <= 1'b0;
      serviced_o  <= 0;
    end else if (busy_r) begin
      irq_clear_o <= 1'b0;
      busy_r      <= !short_irq_n_i;
    end else if (service_en_i && short_irq_n_i === 1'b0) begin
      irq_clear_o <= 1'b1;
      busy_r      <= 1'b1;
      serviced_o  <= serviced_o + 1;
    end
  end
endmodule : ldo_irq_host

// >>> tb_ldo_enable_mode_control.sv
// Purpose: self-checking bench for the regulator enable and mode block
// Assumes: inputs driven at the falling edge
// Notes: expected states come from an integer model of the control tables
`timescale 1ns/10ps
`include "ldo_ctrl_map.svh"
module tb_ldo_enable_mode_control import ldo_ctrl_pkg::*; ;
  logic       clk, rst, rstn_pin, stby, load_s, spe, msk, srv, clr, spe_o, irq_o, irqn_o;
  logic [5:0] sd, en, md, pt, en_o, md_o, pt_o, pd_o;
  logic [5:0] mcap = `MODE_CAPABLE;
  logic [3:0] gsl, gv, gpo;
  logic [7:0] dly;
  logic [1:0] pll, pll_o;
  logic [31:0] r;
  reg_state_t st [6];
  int         fails, cmp_count, seed, served;

  ldo_enable_mode_control i_dut (
    .sys_clk_i(clk), .rst_i(rst), .reset_n_input_i(rstn_pin), .standby_req_i(stby),
    .short_detect_i(sd), .cfg_load_i(load_s), .regulator_enable_bit_i(en),
    .low_power_select_bit_i(md), .standby_participation_bit_i(pt),
    .gpo_standby_low_i(gsl), .gpo_value_i(gv), .sleep_response_delay_i(dly),
    .short_protect_enable_i(spe), .short_circuit_irq_mask_i(msk),
    .short_irq_clear_i(clr), .pll_supply_voltage_select_i(pll),
    .regulator_enable_bit_o(en_o), .low_power_select_bit_o(md_o),
    .standby_participation_bit_o(pt_o), .short_protect_enable_o(spe_o),
    .short_circuit_irq_o(irq_o), .short_irq_n_o(irqn_o),
    .pll_supply_voltage_select_o(pll_o), .reg_state_o(st), .pull_down_o(pd_o), .gpo_o(gpo));

  ldo_irq_host i_host (.sys_clk_i(clk), .rst_i(rst), .short_irq_n_i(irqn_o),
    .service_en_i(srv), .irq_clear_o(clr), .serviced_o(served));

  initial clk = 1'b0;
  always #2 clk = ~clk;

  task automatic check(bit ok, string m);
    cmp_count++;
    if (!ok) begin
      fails++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask : check

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : summarize

  task automatic step(int n);
    repeat (n) @(negedge clk);
  endtask : step

  task automatic load();
    load_s = 1'b1;
    step(1);
    load_s = 1'b0;
    step(2);
  endtask : load

  // integer model of both control tables
  function automatic reg_state_t exp_st(int i, int s);
    int on = en[i];
    int lp = md[i] & mcap[i];
    int sl = pt[i] & s;
    if (on == 0) return REG_OFF;
    if (lp != 0) return REG_LOW_POWER;
    return (sl != 0) ? REG_OFF : REG_ON;
  endfunction : exp_st

  task automatic check_all(int s);
    for (int i = 0; i < 6; i++) begin
      check(st[i] === exp_st(i, s), "regulator state");
      check(pd_o[i] === (exp_st(i, s) == REG_OFF), "pull-down");
    end
    check(en_o === en && pt_o === pt, "readback");
    check(md_o === (md & mcap), "mode readback");
    check(pll_o === pll, "pll select");
    check(gpo === ((s != 0) ? (gv & ~gsl) : gv), "gpo level");
  endtask : check_all

  task automatic rand_cfg();
    r   = $random(seed);
    en  = r[5:0];
    md  = r[11:6];
    pt  = r[17:12];
    gv  = r[21:18];
    gsl = r[25:22];
  endtask : rand_cfg

  initial begin
    seed = 32'h9A0A;
    {rst, rstn_pin, stby, load_s, spe, msk, srv} = 7'b1100000;
    {sd, en, md, pt, gsl, gv, dly, pll} = '0;
    step(12);
    check(en_o === 6'h00 && spe_o === 1'b0 && irqn_o === 1'b1, "reset values");
    check(pd_o === 6'h3F && irq_o === 1'b0, "reset pull-down");
    rst = 1'b0;
    for (int k = 0; k < 16; k++) begin
      rand_cfg();
      pll = k[1:0];
      load();
      check_all(0);
    end
    for (int k = 0; k < 4; k++) begin
      rand_cfg();
      dly = 8'(k * 7);
      load();
      stby = 1'b1;
      step(int'(dly) + 4);
      check_all(0);
      step(4);
      check_all(1);
      stby = 1'b0;
      step(int'(dly) + 4);
      check_all(1);
      step(4);
      check_all(0);
    end
    rstn_pin = 1'b0;
    step(6);
    check(pd_o === 6'h3F, "pin reset pull-down");
    rstn_pin = 1'b1;
    en = 6'h3F;
    md = 6'h00;
    pt = 6'h00;
    load();
    sd = 6'h08;
    step(30);
    check(en_o === 6'h3F && irq_o === 1'b0, "unprotected short");
    sd = 6'h00;
    spe = 1'b1;
    load();
    sd = 6'h09;
    step(30);
    check(en_o === 6'h37 && st[3] === REG_OFF && st[0] === REG_ON, "trip");
    check(irq_o === 1'b1 && irqn_o === 1'b0, "flag raised");
    sd = 6'h00;
    step(10);
    check(irq_o === 1'b1, "flag sticky");
    srv = 1'b1;
    step(6);
    check(irq_o === 1'b0 && served == 1, "flag cleared");
    srv = 1'b0;
    msk = 1'b1;
    load();
    sd = 6'h20;
    step(30);
    check(en_o === 6'h1F && irq_o === 1'b1 && irqn_o === 1'b1, "masked flag");
    sd = 6'h00;
    msk = 1'b0;
    en = 6'h1F;
    load();
    check(irqn_o === 1'b0, "unmasked flag");
    srv = 1'b1;
    step(6);
    check(irq_o === 1'b0 && served == 2, "second clear");
    rst = 1'b1;
    step(1);
    check(spe_o === 1'b0 && en_o === 6'h00 && pd_o === 6'h3F, "mid-run reset");
    rst = 1'b0;
    rand_cfg();
    load();
    check_all(0);
    summarize();
  end

  // watchdog well beyond the expected run length
  initial begin
    #200000;
    fails++;
    summarize();
  end
endmodule : tb_ldo_enable_mode_control
